// File: design/res_sequencer.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module res_sequencer #(
  parameter int unsigned SHORT_CYC = res_pkg::SHORT_CYC,
  parameter int unsigned BLANK_CYC = res_pkg::BLANK_CYC,
  parameter int unsigned STEP_CYC = res_pkg::STEP_CYC,
  parameter int unsigned RAMP_BASE_CYC = res_pkg::RAMP_BASE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and monitors
  input wire logic en_pin,
  input wire logic analog_supply_ok,
  input wire res_pkg::res_otp_t otp_image,
  input wire res_pkg::res_mon_t [3:0] rail_mon,
  // regulator control
  output logic [3:0] rail_run,
  output logic [1:0][7:0] buck_level_code,
  output logic [1:0] buck_slew_mode,
  output logic [1:0] buck_pwm_force,
  output logic [1:0][4:0] linear_level_code,
  output logic [1:0] linear_soft_start,
  output logic aux_output_one,
  output logic aux_output_two,
  output logic pin_pulldown_on
);
  // ==============================================================
  // state
  logic [31:0] ctrl_q, dly_lo_q, dly_hi_q, btgt_q, ltgt_q;
  logic [7:0] mask_q, flag_q;
  logic pend_q, pin_q;
  logic [5:0] fol_q;
  logic [31:0] cnt_q [6];
  logic [3:0] run_q, trip_q, reached_q, valid_q, valid_d, trip_ev;
  logic [31:0] low_cnt_q [4];
  logic [31:0] blank_q [2];
  logic [7:0] cur_q [2];
  logic [31:0] rtick_q [2];
  logic [1:0] pwm_q, aux_q;
  logic [5:0] req;
  logic [7:0] dly [6];
  logic [7:0] set_ev, clr;
  logic wr, rd_hit, soft_wr, live, pin_edge;

  function automatic logic [31:0] dly_cyc(input logic [3:0] c);
    return 32'(c) * STEP_CYC;
  endfunction

  function automatic logic [31:0] ramp_cyc(input logic [2:0] s);
    return RAMP_BASE_CYC << s;
  endfunction

  // ==============================================================
  // apb slave
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1; // see R18
  assign soft_wr = wr && paddr == res_pkg::REG_CTRL && pwdata[res_pkg::CTRL_SOFT_BIT];
  assign live = !pend_q && analog_supply_ok && !soft_wr; // see R17
  assign clr = (wr && paddr == res_pkg::REG_FLAGS) ? pwdata[7:0] : 8'h00;

  always_comb begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      res_pkg::REG_CTRL: prdata = ctrl_q;
      res_pkg::REG_DLY_LO: prdata = dly_lo_q;
      res_pkg::REG_DLY_HI: prdata = dly_hi_q;
      res_pkg::REG_BUCK_TGT: prdata = btgt_q;
      res_pkg::REG_LIN_TGT: prdata = ltgt_q;
      res_pkg::REG_MASK: prdata = {24'h000000, mask_q};
      res_pkg::REG_FLAGS: prdata = {24'h000000, flag_q};
      res_pkg::REG_STATUS: prdata = {20'h00000, pwm_q, aux_q, run_q, valid_q}; // see R6
      default: rd_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_hit;

  // ==============================================================
  // register file, cleared by lockout or soft restart, then reloaded except the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= res_pkg::CTRL_RST;
      dly_lo_q <= res_pkg::DLY_RST;
      dly_hi_q <= res_pkg::DLY_RST;
      btgt_q <= res_pkg::TGT_RST;
      ltgt_q <= res_pkg::TGT_RST;
      mask_q <= res_pkg::MASK_RST;
    end else if (!analog_supply_ok || soft_wr) begin // see R17
      ctrl_q <= res_pkg::CTRL_RST; // see R19
      dly_lo_q <= res_pkg::DLY_RST;
      dly_hi_q <= res_pkg::DLY_RST;
      btgt_q <= res_pkg::TGT_RST;
      ltgt_q <= res_pkg::TGT_RST;
      mask_q <= res_pkg::MASK_RST;
    end else if (pend_q) begin
      ctrl_q <= {1'b0, otp_image.ctrl[30:0]}; // see R19
      dly_lo_q <= otp_image.dly_lo;
      dly_hi_q <= {16'h0000, otp_image.dly_hi[15:0]};
      btgt_q <= {9'h000, otp_image.buck_tgt[22:20], 1'b0, otp_image.buck_tgt[18:0]};
      ltgt_q <= {19'h00000, otp_image.lin_tgt[12:8], 3'h0, otp_image.lin_tgt[4:0]};
    end else if (wr) begin
      unique case (paddr)
        res_pkg::REG_CTRL: ctrl_q <= {11'h000, pwdata[20:16], 4'h0, pwdata[11:0]};
        res_pkg::REG_DLY_LO: dly_lo_q <= pwdata;
        res_pkg::REG_DLY_HI: dly_hi_q <= {16'h0000, pwdata[15:0]};
        res_pkg::REG_BUCK_TGT: btgt_q <= {9'h000, pwdata[22:20], 1'b0, pwdata[18:0]};
        res_pkg::REG_LIN_TGT: ltgt_q <= {19'h00000, pwdata[12:8], 3'h0, pwdata[4:0]};
        res_pkg::REG_MASK: mask_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b1;
    end else begin
      pend_q <= !analog_supply_ok || soft_wr;
    end
  end

  // ==============================================================
  // event flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 8'h00;
    end else if (!analog_supply_ok || soft_wr) begin
      flag_q <= 8'h00;
    end else begin
      flag_q <= (flag_q & ~clr) | set_ev;
    end
  end

  // ==============================================================
  // enable pin delays
  assign pin_edge = en_pin != pin_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dly[i] = dly_lo_q[8*i +: 8];
    end
    for (int i = 0; i < 2; i++) begin
      dly[4+i] = dly_hi_q[8*i +: 8];
    end
    for (int i = 0; i < res_pkg::NCH; i++) begin
      req[i] = ctrl_q[2*i] && (!ctrl_q[2*i+1] || fol_q[i]); // see R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= live && en_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fol_q <= 6'h00;
      for (int i = 0; i < res_pkg::NCH; i++) begin
        cnt_q[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < res_pkg::NCH; i++) begin
        if (!live) begin
          fol_q[i] <= 1'b0;
          cnt_q[i] <= 32'h0000_0000;
        end else if (pin_edge) begin
          // a new edge restarts the countdown, see R21
          cnt_q[i] <= dly_cyc(en_pin ? dly[i][3:0] : dly[i][7:4]); // see R22
          if ((en_pin ? dly[i][3:0] : dly[i][7:4]) == 4'h0) begin
            fol_q[i] <= en_pin; // see R15
          end
        end else if (cnt_q[i] != 32'h0000_0000) begin
          cnt_q[i] <= cnt_q[i] - 32'h0000_0001;
          if (cnt_q[i] == 32'h0000_0001) begin
            fol_q[i] <= pin_q; // see R16
          end
        end
      end
    end
  end

  // ==============================================================
  // rails, short detection, validity
  always_comb begin
    set_ev = 8'h00;
    for (int i = 0; i < res_pkg::NRAIL; i++) begin
      valid_d[i] = rail_mon[i].uv_ok && (rail_mon[i].ov_ok ||
        !ctrl_q[i < 2 ? res_pkg::CTRL_BWIN_BIT : res_pkg::CTRL_LWIN_BIT]); // see R7
      trip_ev[i] = run_q[i] && !rail_mon[i].above &&
        low_cnt_q[i] == SHORT_CYC - 1; // see R3 see R9
      set_ev[i] = trip_ev[i];
      if (i < 2 || blank_q[i-2] == 32'h0000_0000) begin // see R14
        set_ev[4+i] = (valid_d[i] && !valid_q[i] && !mask_q[i]) || // see R4 see R10
          (!valid_d[i] && valid_q[i] && !mask_q[4+i]); // see R5
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
      trip_q <= 4'h0;
      reached_q <= 4'h0;
      valid_q <= 4'h0;
      for (int i = 0; i < res_pkg::NRAIL; i++) begin
        low_cnt_q[i] <= 32'h0000_0000;
      end
    end else begin
      valid_q <= valid_d; // see R6
      for (int i = 0; i < res_pkg::NRAIL; i++) begin
        run_q[i] <= live && req[i] && !trip_q[i] && !trip_ev[i]; // see R1
        trip_q[i] <= req[i] && live && (trip_q[i] || trip_ev[i]);
        reached_q[i] <= run_q[i] && (reached_q[i] || rail_mon[i].above); // see R2
        if (!run_q[i] || rail_mon[i].above) begin
          low_cnt_q[i] <= 32'h0000_0000;
        end else if (low_cnt_q[i] != SHORT_CYC - 1) begin
          low_cnt_q[i] <= low_cnt_q[i] + 32'h0000_0001;
        end
      end
    end
  end

  // ==============================================================
  // linear good blanking after target change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q[0] <= 32'h0000_0000;
      blank_q[1] <= 32'h0000_0000;
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (wr && live && paddr == res_pkg::REG_LIN_TGT &&
            pwdata[8*j +: 5] != ltgt_q[8*j +: 5]) begin
          blank_q[j] <= BLANK_CYC; // see R14
        end else if (blank_q[j] != 32'h0000_0000) begin
          blank_q[j] <= blank_q[j] - 32'h0000_0001;
        end
      end
    end
  end

  // ==============================================================
  // buck voltage ramp and forced pwm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 2'b00;
      for (int b = 0; b < 2; b++) begin
        cur_q[b] <= 8'h00;
        rtick_q[b] <= 32'h0000_0000;
      end
    end else begin
      for (int b = 0; b < 2; b++) begin
        pwm_q[b] <= run_q[b] && (ctrl_q[res_pkg::CTRL_FPWM_BIT+b] ||
          cur_q[b] != btgt_q[8*b +: 8]); // see R13
        if (!run_q[b]) begin
          cur_q[b] <= btgt_q[8*b +: 8];
          rtick_q[b] <= 32'h0000_0000;
        end else if (cur_q[b] == btgt_q[8*b +: 8]) begin
          rtick_q[b] <= 32'h0000_0000;
        end else if (rtick_q[b] >= ramp_cyc(btgt_q[16+4*b +: 3]) - 1) begin // see R12
          rtick_q[b] <= 32'h0000_0000;
          cur_q[b] <= (cur_q[b] < btgt_q[8*b +: 8]) ? cur_q[b] + 8'h01 : cur_q[b] - 8'h01;
        end else begin
          rtick_q[b] <= rtick_q[b] + 32'h0000_0001;
        end
      end
    end
  end

  // ==============================================================
  // aux outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_q <= 2'b00;
    end else begin
      aux_q <= {live && req[5], live && req[4]}; // see R16 see R17
    end
  end

  // ==============================================================
  // outputs
  assign rail_run = run_q;
  assign buck_level_code[0] = cur_q[0];
  assign buck_level_code[1] = cur_q[1];
  assign buck_slew_mode = reached_q[1:0];
  assign buck_pwm_force = pwm_q;
  assign linear_level_code[0] = ltgt_q[4:0];
  assign linear_level_code[1] = ltgt_q[12:8];
  assign linear_soft_start = run_q[3:2] & ~reached_q[3:2]; // see R8
  assign aux_output_one = aux_q[0];
  assign aux_output_two = aux_q[1];
  assign pin_pulldown_on = ctrl_q[res_pkg::CTRL_PD_BIT]; // see R11

  // ==============================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence soft_wr_s;
    psel && penable && pwrite && paddr == res_pkg::REG_CTRL && pwdata[31];
  endsequence

  run_off_a: assert property (!ctrl_q[0] |=> !rail_run[0]) // see R1
    else $error("rail runs with enable bit low");
  run_direct_a: assert property (ctrl_q[1:0] == 2'b01 && live && !trip_q[0] && !trip_ev[0]
    |=> rail_run[0]) // see R1
    else $error("direct enabled rail not running");
  buck_trip_a: assert property (trip_ev[0] |=> !rail_run[0] && flag_q[0]) // see R3
    else $error("buck short not handled");
  lin_trip_a: assert property (trip_ev[2] |=> !rail_run[2] && flag_q[2]) // see R9
    else $error("linear short not handled");
  good_rise_a: assert property (valid_d[0] && !valid_q[0] && !mask_q[0] && analog_supply_ok
    && !soft_wr |=> flag_q[4]) // see R4
    else $error("buck good rise flag missing");
  good_fall_a: assert property (!valid_d[1] && valid_q[1] && !mask_q[5] && analog_supply_ok
    && !soft_wr |=> flag_q[5]) // see R5
    else $error("buck good fall flag missing");
  status_rd_a: assert property (psel && paddr == res_pkg::REG_STATUS |-> prdata[3:0] == valid_q)
    else $error("status does not show validity"); // see R6
  blank_lin_a: assert property (blank_q[0] != 32'h0000_0000 && !flag_q[6] |=> !flag_q[6])
    else $error("linear good flag set while blanked"); // see R14
  pwm_ramp_a: assert property (run_q[0] && cur_q[0] != btgt_q[7:0] |=> buck_pwm_force[0])
    else $error("pwm not forced during ramp"); // see R13
  ramp_step_a: assert property (run_q[0] |=> cur_q[0] == $past(cur_q[0]) ||
    cur_q[0] == $past(cur_q[0]) + 8'h01 || cur_q[0] == $past(cur_q[0]) - 8'h01)
    else $error("ramp jumped more than one code"); // see R12
  soft_clear_a: assert property (soft_wr_s |=> rail_run == 4'h0 && aux_q == 2'b00 ##1
    ctrl_q[31] == 1'b0) // see R17
    else $error("soft restart did not clear");
  uvlo_off_a: assert property (!analog_supply_ok |=> rail_run == 4'h0 && aux_q == 2'b00)
    else $error("outputs on under lockout"); // see R19
  aux_nodelay_a: assert property (pin_edge && live && !en_pin && dly[4][7:4] == 4'h0
    |=> !fol_q[4]) // see R16
    else $error("aux zero delay not immediate");
endmodule
`default_nettype wire

// File: design/res_pkg.sv
//==============================================================
// Function
// R1: enable bit, pin follow and pin select output
// R2: buck ramp slew controlled above short level
// R3: buck short or overload trips and flags
// R4: buck valid rise sets good flag, maskable
// R5: buck valid fall sets good flag, maskable
// R6: status bit mirrors buck output validity
// R7: window select picks undervoltage or both checks
// R8: linear soft start limits rise rate
// R9: linear short or overload trips and flags
// R10: linear good flags, masks and status bit
// R11: pulldown control bit drives pin pulldown
// R12: buck target change ramps at selected speed
// R13: forced pwm during buck voltage change
// R14: linear good events blanked after target change
// R15: pin follow rails use on and off delays
// R16: aux outputs follow pin with delays
// R17: soft restart clears rails, outputs, registers
// R18: bus interface survives soft restart
// R19: supply lockout clears all, reloads on recovery
// R20: host waits after supply rise before access
// R21: new pin edge restarts pending delay
// R22: delays counted in parameter step of cycles
package res_pkg;
  // ==============================================================
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DLY_LO = 8'h04;
  localparam logic [7:0] REG_DLY_HI = 8'h08;
  localparam logic [7:0] REG_BUCK_TGT = 8'h0c;
  localparam logic [7:0] REG_LIN_TGT = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_FLAGS = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // ==============================================================
  // control fields
  localparam int CTRL_PD_BIT = 16;
  localparam int CTRL_BWIN_BIT = 17;
  localparam int CTRL_LWIN_BIT = 18;
  localparam int CTRL_FPWM_BIT = 19;
  localparam int CTRL_SOFT_BIT = 31;
  localparam int NCH = 6;
  localparam int NRAIL = 4;
  // ==============================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DLY_RST = 32'h0000_0000;
  localparam logic [31:0] TGT_RST = 32'h0000_0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  // ==============================================================
  // timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SHORT_TIME_US = 1000;
  localparam int unsigned BLANK_TIME_US = 100;
  localparam int unsigned STEP_TIME_US = 1000;
  localparam int unsigned SHORT_CYC = SHORT_TIME_US * CLK_MHZ;
  localparam int unsigned BLANK_CYC = BLANK_TIME_US * CLK_MHZ;
  localparam int unsigned STEP_CYC = STEP_TIME_US * CLK_MHZ;
  localparam int unsigned RAMP_BASE_CYC = 250;
  // ==============================================================
  // carriers
  typedef struct packed {
    logic above;
    logic uv_ok;
    logic ov_ok;
  } res_mon_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dly_lo;
    logic [31:0] dly_hi;
    logic [31:0] buck_tgt;
    logic [31:0] lin_tgt;
  } res_otp_t;
endpackage

// File: dv/res_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// rail model: output rises two cycles after run, shorted rails stay low
module res_rail_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [3:0] rail_run,
  input wire logic [3:0] short_req,
  input wire logic ov_bad,
  // monitors
  output var res_pkg::res_mon_t [3:0] rail_mon
);
  logic [3:0] run_q;
  logic [3:0] up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
      up_q <= 4'h0;
    end else begin
      run_q <= rail_run;
      up_q <= run_q & rail_run;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rail_mon[i].above = up_q[i] & ~short_req[i];
      rail_mon[i].uv_ok = up_q[i] & ~short_req[i];
      rail_mon[i].ov_ok = ~ov_bad;
    end
  end
endmodule
`default_nettype wire

// File: dv/res_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module res_sequencer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic en_pin = 1'b0;
  logic supply_ok = 1'b1;
  logic [3:0] short_req = 4'h0;
  logic ov_bad = 1'b0;
  res_pkg::res_otp_t otp = '{ctrl: 32'h0001_0000, default: 32'h0000_0000};
  res_pkg::res_mon_t [3:0] rail_mon;
  logic [3:0] rail_run;
  logic [1:0][7:0] buck_code;
  logic [1:0] slew;
  logic [1:0] pwm;
  logic aux1;
  logic aux2;
  logic pd;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ==============================================================
  // clock, design and rail model
  always #2 pclk = ~pclk;
  res_sequencer #(.SHORT_CYC(20), .BLANK_CYC(16), .STEP_CYC(4), .RAMP_BASE_CYC(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_pin(en_pin), .analog_supply_ok(supply_ok), .otp_image(otp), .rail_mon(rail_mon),
    .rail_run(rail_run), .buck_level_code(buck_code), .buck_slew_mode(slew),
    .buck_pwm_force(pwm), .linear_level_code(), .linear_soft_start(),
    .aux_output_one(aux1), .aux_output_two(aux2), .pin_pulldown_on(pd)
  );
  res_rail_model rails (
    .pclk(pclk), .presetn(presetn), .rail_run(rail_run), .short_req(short_req),
    .ov_bad(ov_bad), .rail_mon(rail_mon)
  );
  // ==============================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==============================================================
  // tests
  initial begin
    logic [31:0] q;
    logic e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    step(3);
    rd(res_pkg::REG_CTRL, 32'h0001_0000);
    check(32'(pd), 32'h1);
    rd(res_pkg::REG_FLAGS, 32'h0);
    wr(res_pkg::REG_CTRL, 32'h0);
    step(1);
    check(32'(pd), 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    $display("test boot done");
    wr(res_pkg::REG_DLY_LO, 32'h0000_3200);
    wr(res_pkg::REG_DLY_HI, 32'h0000_0011);
    wr(res_pkg::REG_CTRL, 32'h0000_030c);
    step(4);
    check(32'(rail_run), 32'h0);
    @(posedge pclk);
    en_pin <= 1'b1;
    step(4);
    check({aux1, rail_run}, 32'h0);
    step(4);
    check({aux1, rail_run}, 32'h10);
    step(4);
    check(32'(rail_run), 32'h2);
    step(4);
    check(32'(slew), 32'h2);
    en_pin <= 1'b0;
    step(4);
    en_pin <= 1'b1;
    step(16);
    check({aux1, rail_run}, 32'h12);
    en_pin <= 1'b0;
    step(20);
    check({aux1, rail_run}, 32'h0);
    $display("test pin sequence done");
    wr(res_pkg::REG_FLAGS, 32'hff);
    wr(res_pkg::REG_MASK, 32'h02);
    wr(res_pkg::REG_CTRL, 32'h14);
    step(8);
    rd(res_pkg::REG_FLAGS, 32'h40);
    rd(res_pkg::REG_STATUS, 32'h66);
    ov_bad <= 1'b1;
    wr(res_pkg::REG_CTRL, 32'h0002_0014);
    step(3);
    rd(res_pkg::REG_STATUS, 32'h64);
    ov_bad <= 1'b0;
    wr(res_pkg::REG_CTRL, 32'h14);
    wr(res_pkg::REG_BUCK_TGT, 32'h0000_0400);
    step(2);
    check(32'(pwm), 32'h2);
    step(20);
    check({pwm, buck_code[1]}, 32'h004);
    wr(res_pkg::REG_FLAGS, 32'hff);
    wr(res_pkg::REG_MASK, 32'h0);
    wr(res_pkg::REG_CTRL, 32'h0);
    step(4);
    rd(res_pkg::REG_FLAGS, 32'h60);
    wr(res_pkg::REG_FLAGS, 32'hff);
    wr(res_pkg::REG_LIN_TGT, 32'h0000_0001);
    wr(res_pkg::REG_CTRL, 32'h10);
    step(8);
    rd(res_pkg::REG_FLAGS, 32'h00);
    wr(res_pkg::REG_CTRL, 32'h0);
    step(4);
    $display("test good flags done");
    wr(res_pkg::REG_FLAGS, 32'hff);
    short_req <= 4'b0101;
    wr(res_pkg::REG_CTRL, 32'h11);
    step(30);
    check(32'(rail_run), 32'h0);
    rd(res_pkg::REG_FLAGS, 32'h05);
    wr(res_pkg::REG_FLAGS, 32'h05);
    rd(res_pkg::REG_FLAGS, 32'h00);
    short_req <= 4'h0;
    $display("test short done");
    wr(res_pkg::REG_CTRL, 32'h104);
    step(4);
    check({aux1, rail_run}, 32'h12);
    wr(res_pkg::REG_CTRL, 32'h8000_0000);
    step(3);
    check({aux1, aux2, rail_run}, 32'h0);
    rd(res_pkg::REG_CTRL, 32'h0001_0000);
    wr(res_pkg::REG_CTRL, 32'h104);
    step(4);
    supply_ok <= 1'b0;
    step(2);
    check({pd, aux1, aux2, rail_run}, 32'h0);
    supply_ok <= 1'b1;
    step(3);
    rd(res_pkg::REG_CTRL, 32'h0001_0000);
    check(32'(pd), 32'h1);
    $display("test restart done");
    report_and_stop();
  end
endmodule
`default_nettype wire
